/* File: core/spc_pkg.sv */
// serial port control package: addresses, field positions, reset values, timing
// assumes the oscillator drives clk and a neighbour supplies the variable baud ticks
// Behaviour
// R1: nine-bit modes receive nine data bits then stop; ninth bit goes to rx_ninth_bit.
// R2: nine-bit modes with multiproc_enable raise rx_done_flag only if ninth bit is 1.
// R3: eight-bit mode with multiproc_enable raises rx_done_flag only on valid stop bit.
// R4: shift-register mode ignores multiproc_enable; software should keep it cleared.
// R5: multiprocessor master sends addresses with ninth bit 1, data with ninth bit 0.
// R6: mode bits 00 shift/12, 01 uart8 variable, 10 uart9 /32 or /64, 11 uart9 variable.
// R7: reception is allowed only while the software-written receiver enable is set.
// R8: nine-bit modes transmit tx_ninth_bit as ninth data bit; software sets it freely.
// R9: eight-bit mode without multiproc_enable stores stop bit in rx_ninth_bit.
// R10: tx_done_flag set after eighth shift bit, or at stop start; software clears.
// R11: rx_done_flag set after eighth shift bit, or mid stop bit, filtered; software clears.
// R12: writing serial_buffer loads transmitter and starts; reading returns separate receive register.
// R13: async frame is start 0, eight data lsb first, optional ninth, stop 1.
// R14: shift mode receives when rx_done_flag clear and enabled; async on start bit.
// R15: shift mode moves data on rxd, clock on txd, eight bits lsb first, osc/12.
// R16: one received byte is buffered; an unread byte is overwritten by the next.
package spc_pkg;

	// register addresses on the special function register port
	localparam logic [7:0] SPC_CTRL_ADDR = 8'h98;
	localparam logic [7:0] SPC_BUF_ADDR  = 8'h99;
	localparam logic [7:0] SPC_CTRL_RST  = 8'h00;
	localparam logic [7:0] SPC_BUF_RST   = 8'h00;

	// serial_control field positions
	localparam int MODE_HI_POS  = 7;
	localparam int MODE_LO_POS  = 6;
	localparam int MP_EN_POS    = 5;
	localparam int RX_EN_POS    = 4;
	localparam int TX9_POS      = 3;
	localparam int RX9_POS      = 2;
	localparam int TX_DONE_POS  = 1;
	localparam int RX_DONE_POS  = 0;

	typedef enum logic [1:0] {
		SPC_MODE_SHIFT = 2'h0,
		SPC_MODE_UART8 = 2'h1,
		SPC_MODE_UART9 = 2'h2,
		SPC_MODE_UART9V = 2'h3
	} spc_mode_type;

	// timing, in oscillator cycles and oversample ticks
	localparam int SHIFT_BAUD_DIV = 12;
	localparam int M2_DIV_SLOW    = 64;
	localparam int M2_DIV_FAST    = 32;
	localparam int OVERSAMPLE     = 16;
	localparam logic [3:0] SHIFT_HALF   = 4'(SHIFT_BAUD_DIV / 2);
	localparam logic [3:0] M2_TICK_SLOW = 4'(M2_DIV_SLOW / OVERSAMPLE);
	localparam logic [3:0] M2_TICK_FAST = 4'(M2_DIV_FAST / OVERSAMPLE);
	localparam logic [3:0] OS_LAST      = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] OS_MID       = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] LAST_BIT8    = 4'h7;
	localparam logic [3:0] LAST_BIT9    = 4'h8;
	localparam logic [2:0] SHIFT_LAST   = 3'h7;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_DATA  = 4'h4,
		TX_STOP  = 4'h8
	} spc_tx_state_type;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} spc_rx_state_type;

	typedef enum logic [2:0] {
		SH_IDLE = 3'h1,
		SH_LOW  = 3'h2,
		SH_HIGH = 3'h4
	} spc_sh_state_type;

endpackage

/* File: core/spc_sync.sv */
// two-flop synchroniser for a pin input
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin and synchronised level
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // spc_sync
`default_nettype wire

/* File: core/spc_tick_div.sv */
// free-running divider giving a one-cycle tick every limit cycles
// assumes limit is at least one and clear restarts the count
`timescale 1ns/1ps
`default_nettype none
module spc_tick_div #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// control
	input  wire logic         clear,
	input  wire logic [W-1:0] limit,
	// tick out
	output logic              tick
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	assign tick = (cnt_q == W'(limit - 1'b1)) && !clear;

	always_comb begin
		cnt_d = W'(cnt_q + 1'b1);
		if (clear || tick) begin
			cnt_d = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // spc_tick_div
`default_nettype wire

/* File: core/spc_serial_port.sv */
// serial port with control/status and buffer registers, four modes, multiprocessor filter
// assumes clk is the oscillator and baud_tick16 is a 16x baud pulse on clk
`timescale 1ns/1ps
`default_nettype none
module spc_serial_port
	import spc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// baud source for the variable modes and the mode-2 rate doubler
	input  wire logic       baud_tick16,
	input  wire logic       double_rate,
	// serial pins
	input  wire logic       rxd_i,
	output logic            rxd_o,
	output logic            rxd_oe,
	output logic            txd_o
);
	logic [7:0]       ctrl_q, ctrl_d;
	logic [7:0]       rx_buf_q, rx_buf_d;
	logic [7:0]       rdata_q, rdata_d;
	logic             rxd_s;
	spc_mode_type     mode;
	logic             is_shift, nine;
	logic             multiproc_enable, rx_enable, tx_ninth_bit, rx_done_flag;
	logic             wr_ctrl, wr_buf, rd_ctrl, rd_buf;
	logic             m2_tick, async_tick, half_tick;
	logic             ti_set, rx_accept;
	logic [7:0]       rx_byte;
	logic             rx_ninth_val;

	spc_tx_state_type tx_state_q, tx_state_d;
	logic [3:0]       tx_sub_q, tx_sub_d, tx_bits_q, tx_bits_d;
	logic [8:0]       tx_shift_q, tx_shift_d;
	logic             tx_line, tx_async_done;

	spc_rx_state_type rx_state_q, rx_state_d;
	logic [3:0]       rx_sub_q, rx_sub_d, rx_bits_q, rx_bits_d;
	logic [8:0]       rx_shift_q, rx_shift_d;
	logic             rxd_prev_q;
	logic             rx_async_end, rx_async_ok;

	spc_sh_state_type sh_state_q, sh_state_d;
	logic             sh_tx_q, sh_tx_d;
	logic [2:0]       sh_cnt_q, sh_cnt_d;
	logic [7:0]       sh_data_q, sh_data_d;
	logic             sh_tx_done, sh_rx_done;
	logic             txd_q, txd_d, rxd_o_q, rxd_o_d, rxd_oe_q, rxd_oe_d;

	spc_sync #(
		.RST_VAL(1'b1)
	) u_rxd_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    (rxd_i),
		.q    (rxd_s)
	);

	// mode 2 has a fixed rate from the oscillator, modes 1 and 3 use the neighbour's tick
	spc_tick_div #(
		.W(4)
	) u_m2_div (
		.clk  (clk),
		.rst_n(rst_n),
		.clear(1'b0),
		.limit(double_rate ? M2_TICK_FAST : M2_TICK_SLOW),
		.tick (m2_tick)
	);

	// half-bit ticks of the shift clock, restarted with each shift frame
	spc_tick_div #(
		.W(4)
	) u_shift_div (
		.clk  (clk),
		.rst_n(rst_n),
		.clear(sh_state_q == SH_IDLE),
		.limit(SHIFT_HALF),
		.tick (half_tick)
	);

	assign mode             = spc_mode_type'({ctrl_q[MODE_HI_POS], ctrl_q[MODE_LO_POS]}); // [R6]
	assign is_shift         = (mode == SPC_MODE_SHIFT);
	assign nine             = ctrl_q[MODE_HI_POS];
	assign multiproc_enable = ctrl_q[MP_EN_POS];
	assign rx_enable        = ctrl_q[RX_EN_POS];
	assign tx_ninth_bit     = ctrl_q[TX9_POS];
	assign rx_done_flag     = ctrl_q[RX_DONE_POS];
	assign async_tick       = (mode == SPC_MODE_UART9) ? m2_tick : baud_tick16; // [R6]

	assign wr_ctrl = sfr_wr && (sfr_addr == SPC_CTRL_ADDR);
	assign wr_buf  = sfr_wr && (sfr_addr == SPC_BUF_ADDR);
	assign rd_ctrl = sfr_rd && (sfr_addr == SPC_CTRL_ADDR);
	assign rd_buf  = sfr_rd && (sfr_addr == SPC_BUF_ADDR);

	// async completion: eight-bit mode checks the stop bit, nine-bit the ninth bit
	assign rx_async_ok = !multiproc_enable || (nine ? rx_shift_q[8] : rxd_s); // [R2] [R3]
	assign rx_accept   = (rx_async_end && rx_async_ok) || sh_rx_done; // [R4] [R11]
	assign rx_byte     = is_shift ? sh_data_q : (nine ? rx_shift_q[7:0] : rx_shift_q[8:1]);
	assign rx_ninth_val = nine ? rx_shift_q[8] : rxd_s; // [R1] [R9]
	assign ti_set      = tx_async_done || sh_tx_done; // [R10]

	// registers: hardware sets win over a software write in the same cycle
	always_comb begin
		ctrl_d   = ctrl_q;
		rx_buf_d = rx_buf_q;
		rdata_d  = rdata_q;
		if (wr_ctrl) begin
			ctrl_d = sfr_wdata; // [R7] [R8]
		end
		if (rx_accept) begin
			rx_buf_d = rx_byte; // [R16]
			if (!is_shift) begin
				ctrl_d[RX9_POS] = rx_ninth_val; // [R1] [R9]
			end
			ctrl_d[RX_DONE_POS] = 1'b1; // [R11]
		end
		if (ti_set) begin
			ctrl_d[TX_DONE_POS] = 1'b1; // [R10]
		end
		if (rd_ctrl) begin
			rdata_d = ctrl_q;
		end else if (rd_buf) begin
			rdata_d = rx_buf_q; // [R12]
		end else if (sfr_rd) begin
			rdata_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= SPC_CTRL_RST;
			rx_buf_q <= SPC_BUF_RST;
			rdata_q  <= 8'h00;
		end else begin
			ctrl_q   <= ctrl_d;
			rx_buf_q <= rx_buf_d;
			rdata_q  <= rdata_d;
		end
	end

	// async transmitter; a write while busy restarts the frame
	always_comb begin
		tx_state_d    = tx_state_q;
		tx_sub_d      = tx_sub_q;
		tx_bits_d     = tx_bits_q;
		tx_shift_d    = tx_shift_q;
		tx_async_done = 1'b0;
		if (wr_buf && !is_shift) begin
			tx_state_d = TX_START; // [R12]
			tx_sub_d   = 4'h0;
			tx_bits_d  = 4'h0;
			tx_shift_d = {tx_ninth_bit, sfr_wdata}; // [R8]
		end else if (async_tick && tx_state_q != TX_IDLE) begin
			tx_sub_d = 4'(tx_sub_q + 1'b1);
			if (tx_sub_q == OS_LAST) begin
				case (tx_state_q)
					TX_START: begin
						tx_state_d = TX_DATA;
					end
					TX_DATA: begin
						tx_shift_d = {1'b1, tx_shift_q[8:1]}; // [R13]
						tx_bits_d  = 4'(tx_bits_q + 1'b1);
						if (tx_bits_q == (nine ? LAST_BIT9 : LAST_BIT8)) begin
							tx_state_d    = TX_STOP;
							tx_async_done = 1'b1; // [R10]
						end
					end
					default: begin
						tx_state_d = TX_IDLE;
					end
				endcase
			end
		end
		case (tx_state_q)
			TX_START: tx_line = 1'b0; // [R13]
			TX_DATA:  tx_line = tx_shift_q[0];
			default:  tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= TX_IDLE;
			tx_sub_q   <= 4'h0;
			tx_bits_q  <= 4'h0;
			tx_shift_q <= 9'h1ff;
		end else begin
			tx_state_q <= tx_state_d;
			tx_sub_q   <= tx_sub_d;
			tx_bits_q  <= tx_bits_d;
			tx_shift_q <= tx_shift_d;
		end
	end

	// async receiver; clearing the enable aborts a frame in progress
	always_comb begin
		rx_state_d   = rx_state_q;
		rx_sub_d     = rx_sub_q;
		rx_bits_d    = rx_bits_q;
		rx_shift_d   = rx_shift_q;
		rx_async_end = 1'b0;
		if (is_shift || !rx_enable) begin
			rx_state_d = RX_IDLE; // [R7]
		end else begin
			case (rx_state_q)
				RX_IDLE: begin
					if (rxd_prev_q && !rxd_s) begin
						rx_state_d = RX_START; // [R14]
						rx_sub_d   = 4'h0;
						rx_bits_d  = 4'h0;
					end
				end
				RX_START: begin
					if (async_tick) begin
						rx_sub_d = 4'(rx_sub_q + 1'b1);
						if (rx_sub_q == OS_MID) begin
							// a glitch shorter than half a bit is not a start bit
							rx_state_d = rxd_s ? RX_IDLE : RX_DATA; // [R13]
							rx_sub_d   = 4'h0;
						end
					end
				end
				RX_DATA: begin
					if (async_tick) begin
						rx_sub_d = 4'(rx_sub_q + 1'b1);
						if (rx_sub_q == OS_LAST) begin
							rx_shift_d = {rxd_s, rx_shift_q[8:1]}; // [R13]
							rx_bits_d  = 4'(rx_bits_q + 1'b1);
							if (rx_bits_q == (nine ? LAST_BIT9 : LAST_BIT8)) begin
								rx_state_d = RX_STOP; // [R1]
							end
						end
					end
				end
				RX_STOP: begin
					if (async_tick) begin
						rx_sub_d = 4'(rx_sub_q + 1'b1);
						if (rx_sub_q == OS_LAST) begin
							rx_state_d   = RX_IDLE;
							rx_async_end = 1'b1; // [R11]
						end
					end
				end
				default: begin
					rx_state_d = RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q   <= 4'h0;
			rx_bits_q  <= 4'h0;
			rx_shift_q <= 9'h000;
			rxd_prev_q <= 1'b1;
		end else begin
			rx_state_q <= rx_state_d;
			rx_sub_q   <= rx_sub_d;
			rx_bits_q  <= rx_bits_d;
			rx_shift_q <= rx_shift_d;
			rxd_prev_q <= rxd_s;
		end
	end

	// shift-register mode: half-duplex, clock low then high for each bit
	always_comb begin
		sh_state_d = sh_state_q;
		sh_tx_d    = sh_tx_q;
		sh_cnt_d   = sh_cnt_q;
		sh_data_d  = sh_data_q;
		sh_tx_done = 1'b0;
		sh_rx_done = 1'b0;
		case (sh_state_q)
			SH_IDLE: begin
				if (is_shift && wr_buf) begin
					sh_state_d = SH_LOW; // [R12]
					sh_tx_d    = 1'b1;
					sh_cnt_d   = 3'h0;
					sh_data_d  = sfr_wdata;
				end else if (is_shift && rx_enable && !rx_done_flag) begin
					sh_state_d = SH_LOW; // [R14]
					sh_tx_d    = 1'b0;
					sh_cnt_d   = 3'h0;
				end
			end
			SH_LOW: begin
				if (half_tick) begin
					sh_state_d = SH_HIGH;
					if (!sh_tx_q) begin
						sh_data_d = {rxd_s, sh_data_q[7:1]}; // [R15]
					end
				end
			end
			SH_HIGH: begin
				if (half_tick) begin
					sh_cnt_d = 3'(sh_cnt_q + 1'b1);
					if (sh_tx_q) begin
						sh_data_d = {1'b1, sh_data_q[7:1]}; // [R15]
					end
					if (sh_cnt_q == SHIFT_LAST) begin
						sh_state_d = SH_IDLE;
						sh_tx_done = sh_tx_q; // [R10]
						sh_rx_done = !sh_tx_q; // [R11]
					end else begin
						sh_state_d = SH_LOW;
					end
				end
			end
			default: begin
				sh_state_d = SH_IDLE;
			end
		endcase
		// pins follow the state one cycle later, both together
		txd_d    = is_shift ? (sh_state_q != SH_LOW) : tx_line; // [R15]
		rxd_oe_d = sh_tx_q && (sh_state_q != SH_IDLE);
		rxd_o_d  = sh_data_q[0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_state_q <= SH_IDLE;
			sh_tx_q    <= 1'b0;
			sh_cnt_q   <= 3'h0;
			sh_data_q  <= 8'h00;
			txd_q      <= 1'b1;
			rxd_o_q    <= 1'b1;
			rxd_oe_q   <= 1'b0;
		end else begin
			sh_state_q <= sh_state_d;
			sh_tx_q    <= sh_tx_d;
			sh_cnt_q   <= sh_cnt_d;
			sh_data_q  <= sh_data_d;
			txd_q      <= txd_d;
			rxd_o_q    <= rxd_o_d;
			rxd_oe_q   <= rxd_oe_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign txd_o     = txd_q;
	assign rxd_o     = rxd_o_q;
	assign rxd_oe    = rxd_oe_q;

endmodule // spc_serial_port
`default_nettype wire

/* File: test/spc_port_monitor.sv */
// checker for the serial port register port and pins
// assumes it is bound into spc_serial_port
`timescale 1ns/1ps
`default_nettype none
module spc_port_monitor
	import spc_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// baud and pins
	input wire logic       baud_tick16,
	input wire logic       double_rate,
	input wire logic       rxd_i,
	input wire logic       rxd_o,
	input wire logic       rxd_oe,
	input wire logic       txd_o
);
	logic [7:0] ctrl_q;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic       txd_q;
	wire logic  wr_buf = sfr_wr && sfr_addr == SPC_BUF_ADDR;
	wire logic  is_async = ctrl_q[7:6] != 2'h0;
	wire logic  sh_fall = rxd_oe && txd_q && !txd_o;
	// shadow of the software bits, hardware flags live only in bits 2..0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= SPC_CTRL_RST;
			sh_q   <= 8'h00;
			cnt_q  <= 4'h0;
			txd_q  <= 1'b1;
		end else begin
			if (sfr_wr && sfr_addr == SPC_CTRL_ADDR)
				ctrl_q <= sfr_wdata;
			if (wr_buf && !rxd_oe)
				sh_q <= sfr_wdata;
			cnt_q <= !rxd_oe ? 4'h0 : cnt_q + 4'(sh_fall);
			txd_q <= txd_o;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_unmapped_zero: assert property (
		sfr_rd && sfr_addr != SPC_CTRL_ADDR && sfr_addr != SPC_BUF_ADDR |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_ctrl_readback: assert property (
		sfr_rd && !sfr_wr && sfr_addr == SPC_CTRL_ADDR |=> sfr_rdata[7:3] == ctrl_q[7:3])
		else $error("control readback wrong");
	a_async_start: assert property (wr_buf && is_async |-> ##[1:2] !txd_o)
		else $error("no start bit after buffer write");
	a_shift_start: assert property (
		wr_buf && !is_async && !rxd_oe |-> ##[1:2] (rxd_oe && !txd_o))
		else $error("shift transmit did not start");
	a_low_half: assert property (sh_fall |-> !txd_o [*6] ##1 txd_o)
		else $error("shift clock low half wrong");
	a_high_half: assert property (
		rxd_oe && !txd_q && txd_o && cnt_q != 4'h8 |-> txd_o [*6] ##1 !txd_o)
		else $error("shift clock high half wrong");
	a_lsb_first: assert property (sh_fall |-> rxd_o == sh_q[cnt_q[2:0]])
		else $error("shift data bit order wrong");
	a_eight_bits: assert property ($fell(rxd_oe) |-> cnt_q == 4'h8)
		else $error("shift frame not eight bits");
	a_async_no_drive: assert property (is_async |-> !rxd_oe)
		else $error("data pin driven in async mode");
	c_shift_done: cover property ($fell(rxd_oe));
	c_async_start: cover property (wr_buf && is_async);
	c_unmapped: cover property (sfr_rd && sfr_addr == 8'h9a);
	c_slow_mode2: cover property (wr_buf && !double_rate && ctrl_q[7:6] == 2'h2);
endmodule // spc_port_monitor
bind spc_serial_port spc_port_monitor u_spc_port_monitor (
	.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_tick16(baud_tick16),
	.double_rate(double_rate), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o)
);
`default_nettype wire

/* File: test/spc_far_port.sv */
// far serial port model: async frames both ways, shift-mode data source
// assumes tick is the 16x baud pulse shared with the design
`timescale 1ns/1ps
`default_nettype none
module spc_far_port (
	// clock and baud
	input  wire logic       clk,
	input  wire logic       tick,
	// serial lines
	input  wire logic       line_in,
	output logic            line_out,
	// shift-mode source
	input  wire logic       sh_en,
	input  wire logic [7:0] sh_d,
	// frame capture
	input  wire logic [3:0] nb,
	output logic      [9:0] got,
	output logic      [7:0] got_n
);
	int k = 0;
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			while (!tick)
				@(posedge clk);
		end
	endtask
	// ninth bit is the address flag chosen by the caller
	task automatic send(input logic [8:0] d, input logic stop);
		for (int i = 0; i <= nb + 1; i++) begin
			line_out <= (i == 0) ? 1'b0 : (i > nb) ? stop : d[i - 1];
			tk(16);
		end
		line_out <= 1'b1;
	endtask
	// mid-start check drops a lone low shorter than half a bit, not the repeating shift-clock pulses
	initial begin
		line_out = 1'b1;
		got_n    = 8'h00;
		forever begin
			@(negedge line_in);
			tk(8);
			if (!line_in) begin
				got = 10'h000;
				for (int i = 0; i <= nb; i++) begin
					tk(16);
					got[i] = line_in;
				end
				got_n = got_n + 8'h01;
			end
		end
	end
	always @(negedge line_in or negedge sh_en) begin
		if (!sh_en)
			k = 0;
		else begin
			line_out <= sh_d[k];
			k = (k + 1) % 8;
		end
	end
endmodule // spc_far_port
`default_nettype wire

/* File: test/testbench.sv */
// bench: registers, async receive filtering, async transmit, shift mode
// assumes the far-port model beside the design and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench
	import spc_pkg::*;
;
	logic        clk, rst_n, sfr_wr, sfr_rd, tick, sh_en;
	logic [7:0]  sfr_addr, sfr_wdata, rdata, got_n, n0, prev;
	logic        rxd_o, rxd_oe, txd_o, far_line, ren, mp, b, ok, dbl;
	logic [1:0]  tph;
	logic [3:0]  nb;
	logic [9:0]  got;
	logic [31:0] seed;
	logic [1:0]  m;
	int          k, n_fail, tests_run;
	wire logic   rxd = rxd_oe ? rxd_o : far_line;
	spc_serial_port u_spc_serial_port (
		.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(rdata), .baud_tick16(tick), .double_rate(dbl),
		.rxd_i(rxd), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o)
	);
	spc_far_port u_spc_far_port (
		.clk(clk), .tick(tick), .line_in(txd_o), .line_out(far_line), .sh_en(sh_en),
		.sh_d(seed[15:8]), .nb(nb), .got(got), .got_n(got_n)
	);
	always #20 clk = ~clk;
	// tick rate follows dbl so the far model keeps pace with the mode-2 divider
	always @(negedge clk) begin
		tph <= tph + 2'h1;
		tick <= dbl ? !tph[0] : (tph == 2'h3);
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic rx_ok(input logic en, input logic filt, input logic bit9);
		return en && (!filt || bit9);
	endfunction
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic expire;
		n_fail++;
		$display("[ERR] %0t wait ran out", $time);
		end_sim();
	endtask
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk({2'h0, v & msk}, {2'h0, e & msk});
	endtask
	task automatic wait_bit(input logic [7:0] msk);
		logic [7:0] v;
		for (int i = 0; i < 100; i++) begin
			rd(SPC_CTRL_ADDR, v);
			if ((v & msk) != 8'h00)
				return;
		end
		expire();
	endtask
	initial begin
		clk = 1'b0;
		tick = 1'b0;
		tph = 2'h0;
		dbl = 1'b1;
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sh_en = 1'b0;
		nb = 4'h8;
		seed = 32'h000122e4;
		n_fail = 0;
		tests_run = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		rc(SPC_CTRL_ADDR, 8'hff, SPC_CTRL_RST);
		rc(SPC_BUF_ADDR, 8'hff, SPC_BUF_RST);
		wr(8'h9a, 8'h55);
		rc(8'h9a, 8'hff, 8'h00);
		rc(SPC_CTRL_ADDR, 8'hff, SPC_CTRL_RST);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(SPC_CTRL_ADDR, seed[7:0] & 8'hef);
			rc(SPC_CTRL_ADDR, 8'hff, seed[7:0] & 8'hef);
		end
		prev = SPC_BUF_RST;
		for (int c = 0; c < 24; c++) begin
			seed = lfsr(seed);
			m = 2'(c / 8 + 1);
			{ren, mp, b} = 3'(c);
			nb = (m == 2'h1) ? 4'h8 : 4'h9;
			wr(SPC_CTRL_ADDR, {m, mp, ren, 4'h0});
			u_spc_far_port.send({b, seed[7:0]}, (m == 2'h1) ? b : 1'b1);
			ok = rx_ok(ren, mp, b);
			if (ok)
				prev = seed[7:0];
			rc(SPC_CTRL_ADDR, (m == 2'h1 && mp) ? 8'h01 : 8'h05, {5'h0, ok & b, 1'b0, ok});
			rc(SPC_BUF_ADDR, 8'hff, prev);
		end
		for (int c = 1; c < 4; c++) begin
			seed = lfsr(seed);
			m = 2'(c);
			dbl = (c != 2);
			nb = (c == 1) ? 4'h8 : 4'h9;
			wr(SPC_CTRL_ADDR, {m, 2'h0, seed[8], 3'h0});
			n0 = got_n;
			wr(SPC_BUF_ADDR, seed[7:0]);
			for (k = 0; k < 2000 && got_n == n0; k++)
				@(negedge clk);
			if (k == 2000)
				expire();
			chk(got, (c == 1) ? {2'h1, seed[7:0]} : {1'b1, seed[8], seed[7:0]});
			rc(SPC_CTRL_ADDR, 8'h02, 8'h02);
		end
		seed = lfsr(seed);
		wr(SPC_CTRL_ADDR, 8'h20);
		wr(SPC_BUF_ADDR, seed[7:0]);
		wait_bit(8'h02);
		rc(SPC_CTRL_ADDR, 8'h03, 8'h02);
		sh_en = 1'b1;
		wr(SPC_CTRL_ADDR, 8'h30);
		wait_bit(8'h01);
		rc(SPC_BUF_ADDR, 8'hff, seed[15:8]);
		end_sim();
	end
endmodule // testbench
`default_nettype wire
